// ==== hdl/pfm_pkg.sv ====
/*
 * Constants shared by the port function multiplexer: register indices, reset values,
 * function codes and the pin positions of the alternate functions.
 * Assumes a 32-bit bus where register index n sits at byte address 4*n.
 */
`default_nettype none

package pfm_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [6:0] IDX_F_DATA    = 7'h3C;
    localparam logic [6:0] IDX_F_FUNC2   = 7'h3D;
    localparam logic [6:0] IDX_F_CTRL    = 7'h3E;
    localparam logic [6:0] IDX_F_FUNC    = 7'h3F;
    localparam logic [6:0] IDX_J_DATA    = 7'h4C;
    localparam logic [6:0] IDX_J_FUNC2   = 7'h4D;
    localparam logic [6:0] IDX_J_CTRL    = 7'h4E;
    localparam logic [6:0] IDX_J_FUNC    = 7'h4F;
    localparam logic [6:0] IDX_K_DATA    = 7'h50;
    localparam logic [6:0] IDX_K_FUNC2   = 7'h51;
    localparam logic [6:0] IDX_K_FUNC    = 7'h53;
    localparam logic [6:0] IDX_D_DATA    = 7'h60;
    localparam logic [6:0] IDX_D_FUNC2   = 7'h61;
    localparam logic [6:0] IDX_D_CTRL    = 7'h62;
    localparam logic [6:0] IDX_D_FUNC    = 7'h63;
    localparam logic [6:0] IDX_L_DATA    = 7'h64;
    localparam logic [6:0] IDX_L_FUNC2   = 7'h65;
    localparam logic [6:0] IDX_L_CTRL    = 7'h66;
    localparam logic [6:0] IDX_L_FUNC    = 7'h67;
    localparam int         IDX_LSB       = 2;

    // ------------------------------------------------------------
    // reset values and implemented second-function bits
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SEL       = 8'h00;
    localparam logic [7:0] RST_LATCH     = 8'hFF;
    localparam logic [7:0] J_FUNC2_MASK  = 8'hF0;
    localparam logic [6:0] F_FUNC2_MASK  = 7'h55;

    // ------------------------------------------------------------
    // function codes {second function, function, control}; input-only codes {second function, function}
    // ------------------------------------------------------------
    localparam logic [2:0] CODE_OUT      = 3'h1;
    localparam logic [2:0] CODE_ALT_IN   = 3'h2;
    localparam logic [2:0] CODE_ALT_OUT  = 3'h3;
    localparam logic [2:0] CODE_ALT2_OD  = 3'h5;
    localparam logic [2:0] CODE_IRQ      = 3'h6;
    localparam logic [2:0] CODE_ALT2     = 3'h7;
    localparam logic [1:0] KCODE_CAP     = 2'h1;
    localparam logic [1:0] KCODE_IRQ     = 2'h3;

    // ------------------------------------------------------------
    // alternate pin placement on the second wide port and six-pin port
    // ------------------------------------------------------------
    localparam int         L_PIN_RX      = 0;
    localparam int         L_PIN_OD      = 1;
    localparam int         L_PIN_CLK     = 2;
    localparam int         L_PIN_HSI     = 5;
    localparam logic [7:0] L_ALT2_MASK   = 8'h5E;
    localparam int         D_PIN_HSI     = 1;
    localparam int         D_PIN_RX      = 3;
    localparam int         D_PIN_OD      = 4;
    localparam int         D_PIN_CLK     = 5;
    localparam logic [5:0] D_ALT2_MASK   = 6'h35;

endpackage : pfm_pkg

`default_nettype wire

// ==== hdl/pfm_top.sv ====
/*
 * Pin function multiplexer for five ports: two 8-pin bidirectional ports, a 6-pin and a
 * 7-pin bidirectional port and an 8-pin input-only port, with an Avalon-MM slave.
 * Assumes pins arrive asynchronously, peripheral lines are on clk_in, and the pad ring
 * resolves each pin from its out/oe pair.
 */
// Implementation choice: the Avalon-MM interface to the registers.
`default_nettype none

module pfm_top (
    // clock and reset
    input  wire  logic        clk_in,
    input  wire  logic        rst_in,
    // avalon-mm slave
    input  wire  logic [8:0]  address_in,
    input  wire  logic        read_in,
    input  wire  logic        write_in,
    input  wire  logic [31:0] writedata_in,
    input  wire  logic [3:0]  byteenable_in,
    output logic       [31:0] readdata_out,
    output logic              waitrequest_out,
    // wide port a pins
    input  wire  logic [7:0]  port_j_pin_in,
    output logic       [7:0]  port_j_pin_out,
    output logic       [7:0]  port_j_pin_oe_out,
    // input-only port pins
    input  wire  logic [7:0]  port_k_pin_in,
    // wide port b pins
    input  wire  logic [7:0]  port_l_pin_in,
    output logic       [7:0]  port_l_pin_out,
    output logic       [7:0]  port_l_pin_oe_out,
    // six-pin port pins
    input  wire  logic [5:0]  port_d_pin_in,
    output logic       [5:0]  port_d_pin_out,
    output logic       [5:0]  port_d_pin_oe_out,
    // seven-pin port pins
    input  wire  logic [6:0]  port_f_pin_in,
    output logic       [6:0]  port_f_pin_out,
    output logic       [6:0]  port_f_pin_oe_out,
    // peripheral sources
    input  wire  logic [11:0] long_timer_output_line_in,
    input  wire  logic [2:0]  short_timer_output_line_in,
    input  wire  logic        short_timer_seven_output_in,
    input  wire  logic [7:0]  pattern_output_line_in,
    input  wire  logic        serial_three_transmit_in,
    input  wire  logic        serial_three_clock_in,
    input  wire  logic        fast_serial_one_out_in,
    input  wire  logic        fast_serial_one_clock_in,
    input  wire  logic        serial_two_transmit_in,
    input  wire  logic        serial_two_clock_in,
    input  wire  logic        fast_serial_zero_out_in,
    input  wire  logic        fast_serial_zero_clock_in,
    // peripheral sinks
    output logic       [7:0]  long_timer_capture_line_out,
    output logic       [3:0]  short_timer_input_line_out,
    output logic       [3:0]  external_irq_low_line_out,
    output logic       [7:0]  external_irq_high_line_out,
    output logic       [7:0]  halt_wake_irq_sel_out,
    output logic       [7:0]  halt_wake_capture_sel_out,
    output logic              serial_three_receive_out,
    output logic              serial_three_clock_pin_out,
    output logic              serial_three_clear_to_send_out,
    output logic              fast_serial_one_in_out,
    output logic              serial_two_receive_out,
    output logic              serial_two_clock_pin_out,
    output logic              serial_two_clear_to_send_out,
    output logic              fast_serial_zero_in_out
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // returns {oe, out}; open drain only pulls low and floats a one
    function automatic logic [1:0] pfm_drive(input logic drv_latch, input logic latch,
                                             input logic drv_alt, input logic alt_val,
                                             input logic od);
        logic val;
        logic en;
        val = drv_alt ? alt_val : latch;
        en  = drv_latch | drv_alt;
        if (od) begin
            pfm_drive = {en & ~val, 1'b0};
        end else begin
            pfm_drive = {en, val};
        end
    endfunction : pfm_drive

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [36:0] meta_q;
    logic [36:0] sync_q;
    logic [7:0]  j_pin;
    logic [7:0]  k_pin;
    logic [7:0]  l_pin;
    logic [5:0]  d_pin;
    logic [6:0]  f_pin;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {port_f_pin_in, port_d_pin_in, port_l_pin_in, port_k_pin_in, port_j_pin_in};
            sync_q <= meta_q;
        end
    end

    assign j_pin = sync_q[7:0];
    assign k_pin = sync_q[15:8];
    assign l_pin = sync_q[23:16];
    assign d_pin = sync_q[29:24];
    assign f_pin = sync_q[36:30];

    // ------------------------------------------------------------
    // bus slave: one wait cycle, write lands when waitrequest is low
    // ------------------------------------------------------------
    logic        wait_q;
    logic        wr_fire;
    logic [6:0]  idx;
    logic [7:0]  rd_d;

    assign idx     = address_in[8:pfm_pkg::IDX_LSB];
    assign wr_fire = write_in & ~wait_q & byteenable_in[0];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~((read_in | write_in) & wait_q);
        end
    end

    // write-only selection registers read as zero, as do unmapped words
    always_comb begin
        unique case (idx)
            pfm_pkg::IDX_F_DATA: rd_d = {1'b0, f_pin};
            pfm_pkg::IDX_J_DATA: rd_d = j_pin;
            pfm_pkg::IDX_K_DATA: rd_d = k_pin;
            pfm_pkg::IDX_L_DATA: rd_d = l_pin;
            pfm_pkg::IDX_D_DATA: rd_d = {2'b00, d_pin};
            default:             rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            readdata_out <= 32'h0000_0000;
        end else if (read_in & wait_q) begin
            readdata_out <= {24'h00_0000, rd_d};
        end
    end

    assign waitrequest_out = wait_q;

    // ------------------------------------------------------------
    // selection and latch registers
    // ------------------------------------------------------------
    logic [7:0] j_lat_q, j_cr_q, j_fc_q, j_fc2_q;
    logic [7:0] k_fc_q, k_fc2_q;
    logic [7:0] l_lat_q, l_cr_q, l_fc_q, l_fc2_q;
    logic [5:0] d_lat_q, d_cr_q, d_fc_q, d_fc2_q;
    logic [6:0] f_lat_q, f_cr_q, f_fc_q, f_fc2_q;

    // wide port a clears to inputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            j_lat_q <= pfm_pkg::RST_LATCH;
            j_cr_q  <= pfm_pkg::RST_SEL;
            j_fc_q  <= pfm_pkg::RST_SEL;
            j_fc2_q <= pfm_pkg::RST_SEL;
        end else if (wr_fire) begin
            if (idx == pfm_pkg::IDX_J_DATA) j_lat_q <= writedata_in[7:0];
            if (idx == pfm_pkg::IDX_J_CTRL) j_cr_q <= writedata_in[7:0];
            if (idx == pfm_pkg::IDX_J_FUNC) j_fc_q <= writedata_in[7:0];
            if (idx == pfm_pkg::IDX_J_FUNC2) j_fc2_q <= writedata_in[7:0] & pfm_pkg::J_FUNC2_MASK;
        end
    end

    // input-only functions clear to plain input
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            k_fc_q  <= pfm_pkg::RST_SEL;
            k_fc2_q <= pfm_pkg::RST_SEL;
        end else if (wr_fire) begin
            if (idx == pfm_pkg::IDX_K_FUNC) k_fc_q <= writedata_in[7:0];
            if (idx == pfm_pkg::IDX_K_FUNC2) k_fc2_q <= writedata_in[7:0];
        end
    end

    // wide port b clears to inputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            l_lat_q <= pfm_pkg::RST_LATCH;
            l_cr_q  <= pfm_pkg::RST_SEL;
            l_fc_q  <= pfm_pkg::RST_SEL;
            l_fc2_q <= pfm_pkg::RST_SEL;
        end else if (wr_fire) begin
            if (idx == pfm_pkg::IDX_L_DATA) l_lat_q <= writedata_in[7:0];
            if (idx == pfm_pkg::IDX_L_CTRL) l_cr_q <= writedata_in[7:0];
            if (idx == pfm_pkg::IDX_L_FUNC) l_fc_q <= writedata_in[7:0];
            if (idx == pfm_pkg::IDX_L_FUNC2) l_fc2_q <= writedata_in[7:0];
        end
    end

    // six-pin clears selection, latch to ones
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            d_lat_q <= pfm_pkg::RST_LATCH[5:0];
            d_cr_q  <= pfm_pkg::RST_SEL[5:0];
            d_fc_q  <= pfm_pkg::RST_SEL[5:0];
            d_fc2_q <= pfm_pkg::RST_SEL[5:0];
        end else if (wr_fire) begin
            if (idx == pfm_pkg::IDX_D_DATA) d_lat_q <= writedata_in[5:0];
            if (idx == pfm_pkg::IDX_D_CTRL) d_cr_q <= writedata_in[5:0];
            if (idx == pfm_pkg::IDX_D_FUNC) d_fc_q <= writedata_in[5:0];
            if (idx == pfm_pkg::IDX_D_FUNC2) d_fc2_q <= writedata_in[5:0];
        end
    end

    // seven-pin clears selection, latch to ones
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            f_lat_q <= pfm_pkg::RST_LATCH[6:0];
            f_cr_q  <= pfm_pkg::RST_SEL[6:0];
            f_fc_q  <= pfm_pkg::RST_SEL[6:0];
            f_fc2_q <= pfm_pkg::RST_SEL[6:0];
        end else if (wr_fire) begin
            if (idx == pfm_pkg::IDX_F_DATA) f_lat_q <= writedata_in[6:0];
            if (idx == pfm_pkg::IDX_F_CTRL) f_cr_q <= writedata_in[6:0];
            if (idx == pfm_pkg::IDX_F_FUNC) f_fc_q <= writedata_in[6:0];
            if (idx == pfm_pkg::IDX_F_FUNC2) f_fc2_q <= writedata_in[6:0] & pfm_pkg::F_FUNC2_MASK;
        end
    end

    // ------------------------------------------------------------
    // pin drive decode
    // ------------------------------------------------------------
    logic [7:0] j_out_d, j_oe_d, l_out_d, l_oe_d;
    logic [5:0] d_out_d, d_oe_d;
    logic [6:0] f_out_d, f_oe_d;
    logic [7:0] l_alt2;
    logic [5:0] d_alt2;

    assign l_alt2 = {1'b0, fast_serial_one_clock_in, 1'b0, fast_serial_one_out_in,
                     short_timer_seven_output_in, serial_three_clock_in, serial_three_transmit_in, 1'b0};
    assign d_alt2 = {serial_two_clock_in, serial_two_transmit_in, 1'b0,
                     fast_serial_zero_clock_in, 1'b0, fast_serial_zero_out_in};

    always_comb begin
        logic [2:0] code;
        logic [1:0] drv;
        code = 3'h0;
        drv  = 2'h0;
        j_out_d = 8'h00;
        j_oe_d  = 8'h00;
        l_out_d = 8'h00;
        l_oe_d  = 8'h00;
        d_out_d = 6'h00;
        d_oe_d  = 6'h00;
        f_out_d = 7'h00;
        f_oe_d  = 7'h00;
        for (int i = 0; i < 8; i++) begin
            code = {j_fc2_q[i], j_fc_q[i], j_cr_q[i]};
            // latch or long timer outputs; reserved codes float
            drv = pfm_drive(code == pfm_pkg::CODE_OUT, j_lat_q[i],
                            (code == pfm_pkg::CODE_ALT_OUT) | (code == pfm_pkg::CODE_ALT2),
                            (code == pfm_pkg::CODE_ALT2) ? long_timer_output_line_in[(i % 4) + 8]
                                                         : long_timer_output_line_in[i], 1'b0);
            j_oe_d[i]  = drv[1];
            j_out_d[i] = drv[0];
            code = {l_fc2_q[i], l_fc_q[i], l_cr_q[i]};
            // pattern on 011, per-pin alternate on 111
            // open drain only by code 101 on the open-drain pin
            drv = pfm_drive(code == pfm_pkg::CODE_OUT, l_lat_q[i],
                            (code == pfm_pkg::CODE_ALT_OUT)
                            | ((code == pfm_pkg::CODE_ALT2) & pfm_pkg::L_ALT2_MASK[i])
                            | ((code == pfm_pkg::CODE_ALT2_OD) & (i == pfm_pkg::L_PIN_OD)),
                            (code == pfm_pkg::CODE_ALT_OUT) ? pattern_output_line_in[i] : l_alt2[i],
                            code == pfm_pkg::CODE_ALT2_OD);
            l_oe_d[i]  = drv[1];
            l_out_d[i] = drv[0];
        end
        for (int i = 0; i < 6; i++) begin
            code = {d_fc2_q[i], d_fc_q[i], d_cr_q[i]};
            // serial two and fast serial zero, open drain on one pin
            drv = pfm_drive(code == pfm_pkg::CODE_OUT, d_lat_q[i],
                            ((code == pfm_pkg::CODE_ALT2) & pfm_pkg::D_ALT2_MASK[i])
                            | ((code == pfm_pkg::CODE_ALT2_OD) & (i == pfm_pkg::D_PIN_OD)),
                            d_alt2[i], code == pfm_pkg::CODE_ALT2_OD);
            d_oe_d[i]  = drv[1];
            d_out_d[i] = drv[0];
        end
        for (int i = 0; i < 7; i++) begin
            code = {f_fc2_q[i], f_fc_q[i], f_cr_q[i]};
            // short timer outputs on odd pins; code decode
            drv = pfm_drive(code == pfm_pkg::CODE_OUT, f_lat_q[i],
                            (code == pfm_pkg::CODE_ALT_OUT) & (i % 2 == 1),
                            short_timer_output_line_in[(i / 2) % 3], 1'b0);
            f_oe_d[i]  = drv[1];
            f_out_d[i] = drv[0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            port_j_pin_out    <= 8'h00;
            port_j_pin_oe_out <= 8'h00;
            port_l_pin_out    <= 8'h00;
            port_l_pin_oe_out <= 8'h00;
            port_d_pin_out    <= 6'h00;
            port_d_pin_oe_out <= 6'h00;
            port_f_pin_out    <= 7'h00;
            port_f_pin_oe_out <= 7'h00;
        end else begin
            port_j_pin_out    <= j_out_d;
            port_j_pin_oe_out <= j_oe_d;
            port_l_pin_out    <= l_out_d;
            port_l_pin_oe_out <= l_oe_d;
            port_d_pin_out    <= d_out_d;
            port_d_pin_oe_out <= d_oe_d;
            port_f_pin_out    <= f_out_d;
            port_f_pin_oe_out <= f_oe_d;
        end
    end

    // ------------------------------------------------------------
    // peripheral input routing
    // ------------------------------------------------------------
    logic [7:0] k_irq_sel;
    logic [7:0] k_cap_sel;
    logic [3:0] f_irq_sel;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            k_irq_sel[i] = {k_fc2_q[i], k_fc_q[i]} == pfm_pkg::KCODE_IRQ;
            k_cap_sel[i] = {k_fc2_q[i], k_fc_q[i]} == pfm_pkg::KCODE_CAP;
        end
        for (int i = 0; i < 4; i++) begin
            f_irq_sel[i] = {f_fc2_q[2 * i], f_fc_q[2 * i], f_cr_q[2 * i]} == pfm_pkg::CODE_IRQ;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            long_timer_capture_line_out    <= 8'h00;
            short_timer_input_line_out     <= 4'h0;
            external_irq_low_line_out      <= 4'h0;
            external_irq_high_line_out     <= 8'h00;
            halt_wake_irq_sel_out          <= 8'h00;
            halt_wake_capture_sel_out      <= 8'h00;
            serial_three_receive_out       <= 1'b0;
            serial_three_clock_pin_out     <= 1'b0;
            serial_three_clear_to_send_out <= 1'b0;
            fast_serial_one_in_out         <= 1'b0;
            serial_two_receive_out         <= 1'b0;
            serial_two_clock_pin_out       <= 1'b0;
            serial_two_clear_to_send_out   <= 1'b0;
            fast_serial_zero_in_out        <= 1'b0;
        end else begin
            long_timer_capture_line_out    <= k_pin;
            short_timer_input_line_out     <= {f_pin[6], f_pin[4], f_pin[2], f_pin[0]};
            external_irq_low_line_out      <= {f_pin[6], f_pin[4], f_pin[2], f_pin[0]} & f_irq_sel;
            external_irq_high_line_out     <= k_pin & k_irq_sel;
            halt_wake_irq_sel_out          <= k_irq_sel;
            halt_wake_capture_sel_out      <= k_cap_sel;
            // serial three and fast serial one inputs ungated
            serial_three_receive_out       <= l_pin[pfm_pkg::L_PIN_RX];
            serial_three_clock_pin_out     <= l_pin[pfm_pkg::L_PIN_CLK];
            serial_three_clear_to_send_out <= l_pin[pfm_pkg::L_PIN_CLK];
            fast_serial_one_in_out         <= l_pin[pfm_pkg::L_PIN_HSI];
            // serial two and fast serial zero inputs ungated
            serial_two_receive_out         <= d_pin[pfm_pkg::D_PIN_RX];
            serial_two_clock_pin_out       <= d_pin[pfm_pkg::D_PIN_CLK];
            serial_two_clear_to_send_out   <= d_pin[pfm_pkg::D_PIN_CLK];
            fast_serial_zero_in_out        <= d_pin[pfm_pkg::D_PIN_HSI];
        end
    end

endmodule : pfm_top

`default_nettype wire

// ==== test/pfm_props.sv ====
/* pfm_top port checker; bound from the bench top, sees ports only */
`default_nettype none
module pfm_props (
    input wire logic       clk_in, rst_in, read_in, write_in, waitrequest_out,
    input wire logic [7:0] port_k_pin_in, port_l_pin_in, long_timer_capture_line_out,
    input wire logic [7:0] halt_wake_irq_sel_out, halt_wake_capture_sel_out,
    input wire logic [7:0] port_j_pin_oe_out, port_l_pin_oe_out,
    input wire logic [6:0] port_f_pin_in,
    input wire logic [5:0] port_d_pin_in,
    input wire logic [3:0] short_timer_input_line_out,
    input wire logic [31:0] readdata_out,
    input wire logic       serial_three_receive_out, serial_two_receive_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [1:0] up_q;
    logic [3:0] f_even;
    assign f_even = {port_f_pin_in[6], port_f_pin_in[4], port_f_pin_in[2], port_f_pin_in[0]};
    // routes lag three edges; skip the synchroniser fill after reset
    always_ff @(posedge clk_in) up_q <= rst_in ? 2'h0 : (up_q == 2'h3 ? up_q : up_q + 2'h1);
    sequence req_wait_s; (read_in || write_in) && waitrequest_out; endsequence
    sequence ack_s; !waitrequest_out ##1 waitrequest_out; endsequence
    wait_ack_a: assert property (req_wait_s |=> ack_s) else $error("bus answer late");
    upper_zero_a: assert property (readdata_out[31:8] == 24'h0) else $error("read upper bits set");
    capture_route_a: assert property (up_q == 2'h3 |-> long_timer_capture_line_out == $past(port_k_pin_in, 3))
        else $error("capture route broken");
    timer_route_a: assert property (up_q == 2'h3 |-> short_timer_input_line_out == $past(f_even, 3))
        else $error("timer input route broken");
    serial_three_a: assert property (up_q == 2'h3 |-> serial_three_receive_out == $past(port_l_pin_in[0], 3))
        else $error("receive three route broken");
    serial_two_a: assert property (up_q == 2'h3 |-> serial_two_receive_out == $past(port_d_pin_in[3], 3))
        else $error("receive two route broken");
    wake_excl_a: assert property ((halt_wake_irq_sel_out & halt_wake_capture_sel_out) == 8'h00)
        else $error("wake kinds overlap");
    reset_quiet_a: assert property ($fell(rst_in) |-> (port_j_pin_oe_out | port_l_pin_oe_out) == 8'h00)
        else $error("pin driven after reset");
endmodule : pfm_props
`default_nettype wire

// ==== test/pfm_pins.sv ====
/* far side pins: pad level is the block's drive where enabled, else the outside level; the input-only port gets the outside level inverted */
`default_nettype none
module pfm_pins (
    input wire logic [7:0] pv_in, port_j_pin_out, port_j_pin_oe_out, port_l_pin_out, port_l_pin_oe_out,
    input wire logic [6:0] port_f_pin_out, port_f_pin_oe_out,
    input wire logic [5:0] port_d_pin_out, port_d_pin_oe_out,
    output logic     [7:0] port_j_pin_in, port_k_pin_in, port_l_pin_in,
    output logic     [6:0] port_f_pin_in,
    output logic     [5:0] port_d_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    assign port_k_pin_in = ~pv_in;
    assign port_j_pin_in = (port_j_pin_oe_out & port_j_pin_out) | (~port_j_pin_oe_out & pv_in);
    assign port_l_pin_in = (port_l_pin_oe_out & port_l_pin_out) | (~port_l_pin_oe_out & pv_in);
    assign port_f_pin_in = (port_f_pin_oe_out & port_f_pin_out) | (~port_f_pin_oe_out & pv_in[6:0]);
    assign port_d_pin_in = (port_d_pin_oe_out & port_d_pin_out) | (~port_d_pin_oe_out & pv_in[5:0]);
endmodule : pfm_pins
`default_nettype wire

// ==== test/pfm_top_bench.sv ====
/* bench top: avalon master tasks, stimulus and checks; one clock */
`default_nettype none
module pfm_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in, rst_in, read_in, write_in, waitrequest_out, short_timer_seven_output_in;
    logic serial_three_transmit_in, serial_three_clock_in, fast_serial_one_out_in, fast_serial_one_clock_in;
    logic serial_two_transmit_in, serial_two_clock_in, fast_serial_zero_out_in, fast_serial_zero_clock_in;
    logic serial_three_receive_out, serial_three_clock_pin_out, serial_three_clear_to_send_out;
    logic fast_serial_one_in_out, serial_two_receive_out, serial_two_clock_pin_out;
    logic serial_two_clear_to_send_out, fast_serial_zero_in_out;
    logic [8:0] address_in;
    logic [31:0] writedata_in, readdata_out, per_q, q;
    logic [11:0] long_timer_output_line_in;
    logic [7:0] port_j_pin_in, port_j_pin_out, port_j_pin_oe_out, port_k_pin_in, port_l_pin_in, port_l_pin_out;
    logic [7:0] port_l_pin_oe_out, pattern_output_line_in, long_timer_capture_line_out, pv_q;
    logic [7:0] external_irq_high_line_out, halt_wake_irq_sel_out, halt_wake_capture_sel_out;
    logic [6:0] port_f_pin_in, port_f_pin_out, port_f_pin_oe_out;
    logic [5:0] port_d_pin_in, port_d_pin_out, port_d_pin_oe_out;
    logic [3:0] byteenable_in, short_timer_input_line_out, external_irq_low_line_out;
    logic [2:0] short_timer_output_line_in;
    int miscompares = 0;
    int n_compared = 0;
    assign {long_timer_output_line_in, short_timer_output_line_in, short_timer_seven_output_in,
        pattern_output_line_in, serial_three_transmit_in, serial_three_clock_in, fast_serial_one_out_in,
        fast_serial_one_clock_in, serial_two_transmit_in, serial_two_clock_in, fast_serial_zero_out_in,
        fast_serial_zero_clock_in} = per_q;
    pfm_top dut_u (.*);
    pfm_pins pins_u (.pv_in(pv_q), .*);
    initial begin
        clk_in = 1'h0;
        forever #20 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // whole values only, never read back and modified
    task automatic bus(input logic [6:0] idx, input logic w, input logic [7:0] d);
        @(posedge clk_in);
        address_in <= {idx, 2'h0};
        writedata_in <= {24'h0, d};
        write_in <= w;
        read_in <= !w;
        do @(posedge clk_in); while (waitrequest_out !== 1'h0);
        q = readdata_out;
        write_in <= 1'h0;
        read_in <= 1'h0;
    endtask : bus
    task automatic rd(input logic [6:0] idx, input logic [31:0] exp);
        bus(idx, 1'h0, 8'h00);
        chk(q, exp);
    endtask : rd
    task automatic settle(input int k);
        repeat (4) @(posedge clk_in);
        $display("test %0d done", k);
    endtask : settle
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        end_of_test();
    end
    initial begin
        {rst_in, read_in, write_in, address_in, writedata_in, byteenable_in} = {3'h4, 9'h0, 32'h0, 4'hF};
        pv_q = 8'hA5;
        per_q = 32'h5A3C_96E1;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'h0;
        settle(1);
        chk({port_j_pin_oe_out, port_l_pin_oe_out, port_d_pin_oe_out, port_f_pin_oe_out}, 32'h0);
        bus(pfm_pkg::IDX_K_DATA, 1'h1, 8'h00);
        rd(pfm_pkg::IDX_K_DATA, 32'h5A);
        rd(pfm_pkg::IDX_K_FUNC, 32'h0);
        bus(pfm_pkg::IDX_K_FUNC2, 1'h1, 8'hF0);
        bus(pfm_pkg::IDX_K_FUNC, 1'h1, 8'hFF);
        settle(2);
        chk({halt_wake_irq_sel_out, halt_wake_capture_sel_out}, 32'hF00F);
        chk(external_irq_high_line_out, 32'h50);
        bus(pfm_pkg::IDX_K_FUNC, 1'h1, 8'h00);
        settle(3);
        chk({halt_wake_irq_sel_out, external_irq_high_line_out}, 32'h0);
        bus(pfm_pkg::IDX_F_CTRL, 1'h1, 8'h7F);
        settle(4);
        chk({port_f_pin_oe_out, port_f_pin_out}, 32'h3FFF);
        bus(pfm_pkg::IDX_F_DATA, 1'h1, 8'h2A);
        repeat (3) @(posedge clk_in);
        rd(pfm_pkg::IDX_F_DATA, 32'h2A);
        bus(pfm_pkg::IDX_F_FUNC, 1'h1, 8'h43);
        bus(pfm_pkg::IDX_F_FUNC2, 1'h1, 8'h01);
        settle(5);
        chk({port_f_pin_oe_out, port_f_pin_out[1]}, 32'h7C);
        bus(pfm_pkg::IDX_F_CTRL, 1'h1, 8'h3E);
        settle(6);
        chk(external_irq_low_line_out, 32'h1);
        bus(pfm_pkg::IDX_J_CTRL, 1'h1, 8'hFF);
        bus(pfm_pkg::IDX_J_FUNC, 1'h1, 8'hFF);
        settle(7);
        chk({port_j_pin_oe_out, port_j_pin_out}, 32'hFFA3);
        bus(pfm_pkg::IDX_J_FUNC2, 1'h1, 8'hF0);
        settle(8);
        chk(port_j_pin_out, 32'h53);
        bus(pfm_pkg::IDX_L_CTRL, 1'h1, 8'h02);
        settle(9);
        chk({port_l_pin_oe_out[1], port_l_pin_out[1]}, 32'h3);
        bus(pfm_pkg::IDX_L_FUNC2, 1'h1, 8'h02);
        settle(10);
        chk(port_l_pin_oe_out[1], 32'h0);
        per_q <= 32'h5A3C_9661;
        pv_q <= 8'h3C;
        settle(11);
        chk({port_l_pin_oe_out[1], port_l_pin_out[1]}, 32'h2);
        bus(pfm_pkg::IDX_D_CTRL, 1'h1, 8'h10);
        bus(pfm_pkg::IDX_D_FUNC2, 1'h1, 8'h10);
        settle(12);
        chk({port_d_pin_oe_out[4], port_d_pin_out[4]}, 32'h2);
        chk({serial_three_clock_pin_out, serial_three_clear_to_send_out, fast_serial_one_in_out}, 32'h7);
        chk({serial_two_clock_pin_out, serial_two_clear_to_send_out, fast_serial_zero_in_out}, 32'h6);
        end_of_test();
    end
endmodule : pfm_top_bench
bind pfm_top pfm_props props_u (.*);
`default_nettype wire
